// File: bench/csr_host.sv
`default_nettype none
module csr_host (
   input wire logic clk_sys,
   output logic reg_wr = 1'b0,
   output logic reg_rd = 1'b0,
   output logic [7:0] reg_addr = 8'h00,
   output logic [7:0] reg_wdata = 8'h00,
   input wire logic [7:0] reg_rdata
);
   timeunit 1ns;
   timeprecision 1ps;
   // ====================
   // Byte accesses, one strobe cycle each
   task automatic wr(input logic [7:0] a, input logic [7:0] d);
      @(negedge clk_sys);
      reg_addr = a;
      reg_wdata = d;
      reg_wr = 1'b1;
      @(negedge clk_sys);
      reg_wr = 1'b0;
      reg_wdata = ~d;
   endtask : wr
   task automatic rd(input logic [7:0] a, output logic [7:0] d);
      @(negedge clk_sys);
      reg_addr = a;
      reg_rd = 1'b1;
      @(posedge clk_sys);
      #1 d = reg_rdata;
      @(negedge clk_sys);
      reg_rd = 1'b0;
   endtask : rd
endmodule : csr_host
`default_nettype wire

// File: bench/csr_status_sva.sv
`default_nettype none
module csr_status_sva (
   input wire logic clk_sys,
   input wire logic rst_n,
   input wire logic [7:0] reg_addr,
   input wire logic [7:0] reg_rdata,
   input wire csr_pkg::csr_state_t state_in,
   input wire csr_pkg::csr_fault_t fault_in,
   input wire logic thermal_shutdown,
   input wire logic reverse_assist_pin,
   input wire logic exit_flag_clear,
   input wire logic power_good_flag,
   input wire logic converter_enable,
   input wire logic host_throttle_n,
   input wire logic assist_exit_flag,
   input wire csr_pkg::csr_loops_t loops
);
   timeunit 1ns;
   timeprecision 1ps;
   // ====================
   // Port checks
   default clocking @(posedge clk_sys); endclocking
   default disable iff (!rst_n);
   AST_RESET_ZERO: assert property ($rose(rst_n) |-> reg_rdata == 8'h00)
      else $error("read data not zero after reset");
   AST_RSVD_ZERO: assert property (reg_addr == 8'h21 |=> !reg_rdata[1])
      else $error("reserved status bit reads one");
   AST_PG_INPUT: assert property (!state_in.input_present [*4] |-> !power_good_flag)
      else $error("power good without input");
   AST_PG_THERMAL: assert property (thermal_shutdown [*4] |-> !power_good_flag)
      else $error("power good during thermal shutdown");
   AST_OV_CONV_OFF: assert property ($rose(fault_in.system_overvoltage)
      |-> ##[1:5] !converter_enable)
      else $error("converter still on after overvoltage");
   // Assist exit re-enables the loops in the same cycle that the exit flag rises
   AST_EXIT_THROTTLE: assert property ($rose(loops.vlim_loop_en) |-> !host_throttle_n)
      else $error("throttle not low at assist exit");
   AST_EXIT_HOLD: assert property (assist_exit_flag && !exit_flag_clear |=>
      assist_exit_flag)
      else $error("exit flag dropped without clear");
   AST_ENTRY_LOOPS: assert property (
      $rose(loops.system_voltage_throttle_source_en) |->
      !(loops.vlim_loop_en | loops.current_limit_pin_function_loop_en | loops.critical_current_detect_en |
      loops.current_limit_pin_function_en | loops.adapter_ok_throttle_source_en))
      else $error("loops left on at assist entry");
   AST_EXIT_LOOPS: assert property ($rose(loops.vlim_loop_en) |->
      loops.current_limit_pin_function_loop_en && loops.critical_current_detect_en &&
      loops.current_limit_pin_function_en)
      else $error("loops not all back at assist exit");
   AST_PIN_LOW_OFF: assert property (!reverse_assist_pin [*6] |-> loops.vlim_loop_en)
      else $error("assist kept with request pin low");
   cover property ($fell(host_throttle_n));
   cover property ($rose(loops.system_voltage_throttle_source_en));
   cover property ($fell(converter_enable));
endmodule : csr_status_sva
bind csr_status csr_status_sva u_sva (.clk_sys, .rst_n, .reg_addr, .reg_rdata, .state_in,
   .fault_in, .thermal_shutdown, .reverse_assist_pin, .exit_flag_clear, .power_good_flag,
   .converter_enable, .host_throttle_n, .assist_exit_flag, .loops);
`default_nettype wire

// File: bench/csr_status_test.sv
`default_nettype none
module csr_status_test;
   timeunit 1ns;
   timeprecision 1ps;
   localparam logic [7:0] EXP [6] = '{8'h01, 8'h04, 8'h08, 8'h10, 8'h40, 8'h80};
   logic clk_sys = 1'b0;
   logic rst_n = 1'b0;
   logic reg_wr, reg_rd;
   logic [7:0] reg_addr, reg_wdata, reg_rdata;
   csr_pkg::csr_state_t state_in = '0;
   csr_pkg::csr_fault_t fault_in = '0;
   logic thermal_shutdown = 1'b0, battery_overvoltage = 1'b0, restart_failed_pulse = 1'b0;
   logic reverse_assist_pin = 1'b0, exit_flag_clear = 1'b0;
   logic power_good_flag, converter_enable, host_throttle_n, assist_exit_flag;
   csr_pkg::csr_loops_t loops;
   int errors = 0, n_compared = 0;
   always #5 clk_sys = ~clk_sys;
   csr_host host (.clk_sys, .reg_wr, .reg_rd, .reg_addr, .reg_wdata, .reg_rdata);
   csr_status dut (.clk_sys, .rst_n, .reg_wr, .reg_rd, .reg_addr, .reg_wdata, .reg_rdata,
      .state_in, .fault_in, .thermal_shutdown, .battery_overvoltage, .restart_failed_pulse,
      .reverse_assist_pin, .exit_flag_clear, .power_good_flag, .converter_enable,
      .host_throttle_n, .assist_exit_flag, .loops);
   // ====================
   // Helpers
   task automatic chk(input string name, input logic [7:0] exp, input logic [7:0] got);
      n_compared++;
      if (got !== exp) begin
         errors++;
         $display("BAD %s exp %h got %h", name, exp, got);
      end
   endtask : chk
   task automatic rchk(input logic [7:0] a, input logic [7:0] exp);
      logic [7:0] d;
      host.rd(a, d);
      chk($sformatf("reg %h", a), exp, d);
   endtask : rchk
   task automatic idle(input int n);
      repeat (n) @(negedge clk_sys);
   endtask : idle
   task automatic end_sim;
      $display("errors %0d compared %0d", errors, n_compared);
      if (errors == 0 && n_compared > 0) begin
         $display("Run complete: PASS");
      end else begin
         $display("Run complete: FAIL");
      end
      $finish;
   endtask : end_sim
   // ====================
   // Scenarios
   initial begin
      idle(2);
      rst_n = 1'b1;
      chk("loops", 8'h3E, {2'b00, loops});
      chk("exit", 8'h01, {6'h00, assist_exit_flag, host_throttle_n});
      chk("conv", 8'h01, {7'h00, converter_enable});
      rchk(8'h20, 8'h00);
      rchk(8'h21, 8'h00);
      for (int i = 0; i < 6; i++) begin
         state_in = csr_pkg::csr_state_t'(6'h01 << i);
         idle(5);
         rchk(8'h21, EXP[i]);
         chk("pg", (i == 5) ? 8'h01 : 8'h00, {7'h00, power_good_flag});
      end
      state_in = '1;
      host.wr(8'h21, 8'hFF);
      rchk(8'h21, 8'hDD);
      rchk(8'h00, 8'h00);
      thermal_shutdown = 1'b1;
      idle(4);
      chk("pg", 8'h00, {7'h00, power_good_flag});
      thermal_shutdown = 1'b0;
      battery_overvoltage = 1'b1;
      idle(4);
      chk("pg", 8'h00, {7'h00, power_good_flag});
      battery_overvoltage = 1'b0;
      fault_in = '1;
      idle(4);
      fault_in = '0;
      idle(4);
      chk("conv", 8'h00, {7'h00, converter_enable});
      rchk(8'h20, 8'hF7);
      rchk(8'h20, 8'h10);
      host.wr(8'h20, 8'h00);
      rchk(8'h20, 8'h00);
      chk("conv", 8'h01, {7'h00, converter_enable});
      for (int i = 1; i <= 7; i++) begin
         restart_failed_pulse = 1'b1;
         idle(3);
         restart_failed_pulse = 1'b0;
         idle(3);
         rchk(8'h20, (i == 7) ? 8'h08 : 8'h00);
      end
      host.wr(8'h20, 8'h00);
      rchk(8'h20, 8'h00);
      // Unplugging the adapter also clears a latched system overvoltage
      fault_in.system_overvoltage = 1'b1;
      idle(4);
      chk("conv", 8'h00, {7'h00, converter_enable});
      fault_in = '0;
      state_in.input_present = 1'b0;
      idle(4);
      chk("conv", 8'h01, {7'h00, converter_enable});
      rchk(8'h20, 8'h00);
      state_in = '1;
      idle(4);
      host.wr(8'h32, 8'h20);
      rchk(8'h32, 8'h20);
      reverse_assist_pin = 1'b1;
      idle(6);
      rchk(8'h21, 8'hDD);
      host.wr(8'h32, 8'h00);
      idle(6);
      rchk(8'h21, 8'hFD);
      chk("loops", 8'h01, {2'b00, loops});
      reverse_assist_pin = 1'b0;
      idle(6);
      chk("exit", 8'h02, {6'h00, assist_exit_flag, host_throttle_n});
      chk("loops", 8'h3C, {2'b00, loops} & 8'h3C);
      exit_flag_clear = 1'b1;
      idle(1);
      exit_flag_clear = 1'b0;
      idle(2);
      chk("exit", 8'h01, {6'h00, assist_exit_flag, host_throttle_n});
      reverse_assist_pin = 1'b1;
      idle(6);
      rchk(8'h21, 8'hFD);
      fault_in.adapter_overcurrent = 1'b1;
      idle(4);
      fault_in = '0;
      idle(4);
      rchk(8'h21, 8'hDD);
      chk("exit", 8'h02, {6'h00, assist_exit_flag, host_throttle_n});
      end_sim();
   end
   initial begin
      #100000;
      errors++;
      end_sim();
   end
endmodule : csr_status_test
`default_nettype wire

// File: common/csr_pkg.sv
`default_nettype none
package csr_pkg;
   // ==========================================================
   // Register map
   localparam logic [7:0] CSR_ADDR_LO = 8'h20;
   localparam logic [7:0] CSR_ADDR_HI = 8'h21;
   localparam logic [7:0] CSR_ADDR_CTRL = 8'h32;
   localparam logic [15:0] CSR_RESET = 16'h0000;
   localparam logic [7:0] CSR_BYTE_ZERO = 8'h00;
   // Upper byte fields
   localparam int CSR_B_INPUT = 7;
   localparam int CSR_B_ICO = 6;
   localparam int CSR_B_ASSIST = 5;
   localparam int CSR_B_VLIM = 4;
   localparam int CSR_B_CURRENT_LIMIT_PIN_FUNCTION = 3;
   localparam int CSR_B_FAST = 2;
   localparam int CSR_B_REV = 0;
   // Lower byte fields
   localparam int CSR_F_ADP_OV = 7;
   localparam int CSR_F_BAT_OC = 6;
   localparam int CSR_F_ADP_OC = 5;
   localparam int CSR_F_SYS_OV = 4;
   localparam int CSR_F_SYS_UV = 3;
   localparam int CSR_F_CONV_OFF = 2;
   localparam int CSR_F_REV_OV = 1;
   localparam int CSR_F_REV_UV = 0;
   // Control bit that vetoes assist mode
   localparam int CSR_CTRL_ASSIST_DIS = 5;
   // Failed restarts before the system undervoltage fault latches
   localparam int CSR_UV_TRIES = 7;

   typedef struct packed {
      logic input_present;
      logic optimizer_done;
      logic vlim_regulating;
      logic current_limit_pin_function_regulating;
      logic fast_charge;
      logic reverse_output;
   } csr_state_t;

   typedef struct packed {
      logic adapter_overvoltage;
      logic battery_overcurrent;
      logic adapter_overcurrent;
      logic system_overvoltage;
      logic restart_failed;
      logic converter_forced_off;
      logic reverse_output_overvoltage_fault;
      logic reverse_output_undervoltage_fault;
   } csr_fault_t;

   typedef struct packed {
      logic vlim_loop_en;
      logic current_limit_pin_function_loop_en;
      logic critical_current_detect_en;
      logic current_limit_pin_function_en;
      logic adapter_ok_throttle_source_en;
      logic system_voltage_throttle_source_en;
   } csr_loops_t;
endpackage : csr_pkg
`default_nettype wire

// File: hw/csr_status.sv
`default_nettype none
// Notes on behaviour
// - Status is 16 bits over two byte addresses, all zero after reset.
// - Input present bit follows the bus voltage in-range indication.
// - Power good never asserts unless input is present.
// - Power good drops on forced-off, adapter overcurrent, thermal, system faults or battery overvoltage.
// - Optimizer done bit set once the optimizer routine completes.
// - Assist mode entry follows the host command when no fault is present, ignoring throttle.
// - Assist mode leaves on host command or on any fault.
// - On assist exit, set exit flag and hold throttle low until host clears.
// - Assist requested by pin high with control bit 5 low.
// - Assist entry disables limit loops, critical detect, limit pin; swaps throttle source.
// - Assist exit re-enables limit loops, critical detect and limit pin.
// - Voltage limit bit shows forward limiting or reverse voltage regulation.
// - Current limit bit is one while forward input current limiting.
// - Fast charge bit follows fast charge state.
// - Reverse output bit follows reverse output mode.
// - Read-only fault flags latch on trigger and clear on host read.
// - System overvoltage latches, keeps converter off, cleared by writing zero or unplug.
// - Undervoltage fault set after seven failed restarts, cleared by writing zero.
module csr_status (
   input wire logic clk_sys,
   input wire logic rst_n,
   // Register port from the serial slave
   input wire logic reg_wr,
   input wire logic reg_rd,
   input wire logic [7:0] reg_addr,
   input wire logic [7:0] reg_wdata,
   output logic [7:0] reg_rdata,
   // Analog status and fault levels
   input wire csr_pkg::csr_state_t state_in,
   input wire csr_pkg::csr_fault_t fault_in,
   input wire logic thermal_shutdown,
   input wire logic battery_overvoltage,
   input wire logic restart_failed_pulse,
   input wire logic reverse_assist_pin,
   input wire logic exit_flag_clear,
   output logic power_good_flag,
   output logic converter_enable,
   output logic host_throttle_n,
   output logic assist_exit_flag,
   output csr_pkg::csr_loops_t loops
);
   // ==========================================================
   // Input synchronisation
   localparam int SW = $bits(csr_pkg::csr_state_t) + $bits(csr_pkg::csr_fault_t) + 4;
   logic [SW-1:0] sync_v;
   csr_pkg::csr_state_t st;
   csr_pkg::csr_fault_t ft;
   logic therm_s, batov_s, uvp_s, pin_s;

   csr_sync #(.WIDTH(SW)) u_sync (
      .clk_sys(clk_sys),
      .rst_n(rst_n),
      .async_in({state_in, fault_in, thermal_shutdown, battery_overvoltage,
                 restart_failed_pulse, reverse_assist_pin}),
      .sync_out(sync_v)
   );
   assign {st, ft, therm_s, batov_s, uvp_s, pin_s} = sync_v;

   // ==========================================================
   // Register state
   logic [7:0] ctrl_q;
   logic [7:0] fault_q;
   logic [7:0] fault_d;
   logic assist_q, assist_d;
   logic exit_q, exit_d;
   logic uvp_prev_q;
   logic [2:0] uv_cnt_q, uv_cnt_d;
   csr_pkg::csr_loops_t loops_q, loops_d;
   logic [7:0] rdata_q;

   // ==========================================================
   // Decode
   wire sel_lo = reg_addr == csr_pkg::CSR_ADDR_LO;
   wire sel_hi = reg_addr == csr_pkg::CSR_ADDR_HI;
   wire sel_ctrl = reg_addr == csr_pkg::CSR_ADDR_CTRL;
   wire wr_lo = reg_wr && sel_lo;
   wire rd_lo = reg_rd && sel_lo;
   wire wr_ctrl = reg_wr && sel_ctrl;
   wire uvp_edge = uvp_s && !uvp_prev_q;
   wire uv_trip = uvp_edge && (uv_cnt_q == 3'(csr_pkg::CSR_UV_TRIES - 1));
   wire any_fault = |ft || therm_s || batov_s || |fault_q;
   wire assist_req = pin_s && !ctrl_q[csr_pkg::CSR_CTRL_ASSIST_DIS];

   // Fault latches: set wins over clear, so a trigger is never lost to a read
   logic [7:0] fault_set;
   always_comb begin
      fault_set = csr_pkg::CSR_BYTE_ZERO;
      fault_set[csr_pkg::CSR_F_ADP_OV] = ft.adapter_overvoltage;
      fault_set[csr_pkg::CSR_F_BAT_OC] = ft.battery_overcurrent;
      fault_set[csr_pkg::CSR_F_ADP_OC] = ft.adapter_overcurrent;
      fault_set[csr_pkg::CSR_F_SYS_OV] = ft.system_overvoltage;
      fault_set[csr_pkg::CSR_F_SYS_UV] = uv_trip;
      fault_set[csr_pkg::CSR_F_CONV_OFF] = ft.converter_forced_off;
      fault_set[csr_pkg::CSR_F_REV_OV] = ft.reverse_output_overvoltage_fault;
      fault_set[csr_pkg::CSR_F_REV_UV] = ft.reverse_output_undervoltage_fault;
   end
   // The two writable bits survive a read; every other flag clears on it
   wire [7:0] wr_mask = (8'h01 << csr_pkg::CSR_F_SYS_OV) | (8'h01 << csr_pkg::CSR_F_SYS_UV);
   wire [7:0] rd_clr_mask = ~wr_mask;

   always_comb begin
      fault_d = fault_q;
      if (rd_lo) begin
         fault_d = fault_q & ~rd_clr_mask;
      end
      if (wr_lo) begin
         // Only the two writable bits react; writing zero clears them
         fault_d = fault_d & (reg_wdata | ~wr_mask);
      end
      if (!st.input_present) begin
         fault_d[csr_pkg::CSR_F_SYS_OV] = 1'b0;
      end
      fault_d = fault_d | fault_set;
   end

   always_comb begin
      uv_cnt_d = uv_cnt_q;
      if (wr_lo && !reg_wdata[csr_pkg::CSR_F_SYS_UV]) begin
         uv_cnt_d = '0;
      end else if (uvp_edge) begin
         uv_cnt_d = uv_trip ? '0 : uv_cnt_q + 3'h1;
      end
   end

   // Assist mode: entry on command with no fault, exit on command or fault
   always_comb begin
      assist_d = assist_q;
      exit_d = exit_q;
      if (exit_flag_clear) begin
         exit_d = 1'b0;
      end
      if (assist_q && (!assist_req || any_fault)) begin
         assist_d = 1'b0;
         exit_d = 1'b1;
      end else if (!assist_q && assist_req && !any_fault) begin
         assist_d = 1'b1;
      end
   end

   always_comb begin
      loops_d = loops_q;
      if (assist_d && !assist_q) begin
         loops_d = '{vlim_loop_en: 1'b0, current_limit_pin_function_loop_en: 1'b0,
            critical_current_detect_en: 1'b0, current_limit_pin_function_en: 1'b0,
            adapter_ok_throttle_source_en: 1'b0,
            system_voltage_throttle_source_en: 1'b1};
      end else if (!assist_d && assist_q) begin
         loops_d.vlim_loop_en = 1'b1;
         loops_d.current_limit_pin_function_loop_en = 1'b1;
         loops_d.critical_current_detect_en = 1'b1;
         loops_d.current_limit_pin_function_en = 1'b1;
      end
   end

   // ==========================================================
   // Read data
   // Reserved bit 1 keeps the zero default
   logic [7:0] hi_byte;
   always_comb begin
      hi_byte = csr_pkg::CSR_BYTE_ZERO;
      hi_byte[csr_pkg::CSR_B_INPUT] = st.input_present;
      hi_byte[csr_pkg::CSR_B_ICO] = st.optimizer_done;
      hi_byte[csr_pkg::CSR_B_ASSIST] = assist_q;
      hi_byte[csr_pkg::CSR_B_VLIM] = st.vlim_regulating;
      hi_byte[csr_pkg::CSR_B_CURRENT_LIMIT_PIN_FUNCTION] = st.current_limit_pin_function_regulating;
      hi_byte[csr_pkg::CSR_B_FAST] = st.fast_charge;
      hi_byte[csr_pkg::CSR_B_REV] = st.reverse_output;
   end
   wire [7:0] rd_mux = sel_hi ? hi_byte :
                       sel_lo ? fault_q :
                       sel_ctrl ? ctrl_q : csr_pkg::CSR_BYTE_ZERO;

   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         ctrl_q <= csr_pkg::CSR_BYTE_ZERO;
      end else if (wr_ctrl) begin
         ctrl_q <= reg_wdata;
      end
   end

   // Fault latches and the failed restart counter
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         fault_q <= csr_pkg::CSR_RESET[7:0];
         uvp_prev_q <= 1'b0;
         uv_cnt_q <= '0;
      end else begin
         fault_q <= fault_d;
         uvp_prev_q <= uvp_s;
         uv_cnt_q <= uv_cnt_d;
      end
   end

   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         assist_q <= 1'b0;
         exit_q <= 1'b0;
      end else begin
         assist_q <= assist_d;
         exit_q <= exit_d;
      end
   end

   // Loop enables start as in normal charging, outside assist mode
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         loops_q <= '{default: 1'b1, adapter_ok_throttle_source_en: 1'b1,
            system_voltage_throttle_source_en: 1'b0};
      end else begin
         loops_q <= loops_d;
      end
   end

   // Registered read data, so the slave sees a byte that holds for the whole cycle
   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         rdata_q <= csr_pkg::CSR_BYTE_ZERO;
      end else begin
         rdata_q <= rd_mux;
      end
   end

   // ==========================================================
   // Outputs
   // Power good needs input present and no blocking fault
   assign power_good_flag = st.input_present && !ft.converter_forced_off
      && !ft.adapter_overcurrent && !therm_s && !fault_q[csr_pkg::CSR_F_SYS_OV]
      && !fault_q[csr_pkg::CSR_F_SYS_UV] && !batov_s;
   assign converter_enable = !fault_q[csr_pkg::CSR_F_SYS_OV];
   assign host_throttle_n = !exit_q;
   assign assist_exit_flag = exit_q;
   assign loops = loops_q;
   assign reg_rdata = rdata_q;
endmodule : csr_status
`default_nettype wire

// File: hw/csr_sync.sv
`default_nettype none
// Two-flop synchroniser for a bundle of asynchronous levels
module csr_sync #(
   parameter int WIDTH = 1
) (
   input wire logic clk_sys,
   input wire logic rst_n,
   input wire logic [WIDTH-1:0] async_in,
   output logic [WIDTH-1:0] sync_out
);
   logic [WIDTH-1:0] meta_q;
   logic [WIDTH-1:0] sync_q;

   always_ff @(posedge clk_sys or negedge rst_n) begin
      if (!rst_n) begin
         meta_q <= '0;
         sync_q <= '0;
      end else begin
         meta_q <= async_in;
         sync_q <= meta_q;
      end
   end

   assign sync_out = sync_q;
endmodule : csr_sync
`default_nettype wire
